// ===== design/sms_pkg.sv
// Shared constants and types for the switch management serial slave.
package sms_pkg;

   // ****************************************************************
   // Mode strap and selected mode
   // ****************************************************************
   localparam logic [1:0] STRAP_SPI  = 2'h0;
   localparam logic [1:0] STRAP_I2C  = 2'h1;
   localparam logic [1:0] STRAP_MDIO = 2'h2;
   // Core clock edges counted after reset release before the edge at which the synchronised strap is taken.
   localparam logic [1:0] STRAP_TAKE = 2'h2;

   typedef enum logic [1:0] {MODE_NONE, MODE_SPI, MODE_I2C, MODE_MDIO} sms_mode_t;

   // ****************************************************************
   // Four-wire serial frame positions, counted in rising link edges
   // ****************************************************************
   localparam logic [5:0] SPI_HDR_LAST   = 6'h1a;
   localparam logic [5:0] SPI_DATA_FIRST = 6'h20;
   localparam logic [5:0] SPI_DATA_LAST  = 6'h27;
   localparam logic [5:0] SPI_DATA_WRAP  = 6'h28;
   localparam logic [5:0] SPI_DATA_NEXT  = 6'h21;
   localparam logic [2:0] SPI_CMD_RD     = 3'h3;
   localparam logic [2:0] SPI_CMD_WR     = 3'h2;

   // ****************************************************************
   // Two-wire bus slave
   // ****************************************************************
   localparam logic [6:0] I2C_DEV_ADDR = 7'h5f;
   localparam logic [3:0] I2C_LAST_BIT = 4'h7;
   localparam logic [3:0] I2C_ACK_BIT  = 4'h8;

   // ****************************************************************
   // Management data frame
   // ****************************************************************
   localparam logic [5:0]  MDIO_PRE_ONES = 6'h20;
   localparam logic [3:0]  MDIO_HDR_LAST = 4'hc;
   localparam logic [3:0]  MDIO_TA_LAST  = 4'h1;
   localparam logic [3:0]  MDIO_DAT_LAST = 4'hf;
   localparam logic [1:0]  MDIO_OP_RD    = 2'h2;
   localparam logic [1:0]  MDIO_OP_WR    = 2'h1;
   localparam logic [4:0]  PHY_FIRST     = 5'h01;
   localparam logic [4:0]  PHY_LAST      = 5'h04;
   localparam logic [15:0] PHY_REG_BASE  = 16'h0100;

   // One byte access toward the internal register file.
   typedef struct packed {
      logic        we;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } sms_req_t;

endpackage

// ===== design/sms_tgl_sync.sv
// Toggle to pulse crossing into the core clock domain.
`timescale 1ns/10ps
module sms_tgl_sync (
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic tgl_in,
   output logic      pulse_out
);

   logic s1_r;
   logic s2_r;
   logic s3_r;

   // Two synchronising stages, then one stage for the edge.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end else begin
         s1_r <= tgl_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // Each toggle of the source gives one core cycle pulse.
   assign pulse_out = s2_r ^ s3_r;

endmodule // sms_tgl_sync

// ===== design/sms_mgmt_slave.sv
// Management serial slave: four-wire, two-wire and management data modes.
// What this block does
// - Strap at reset release picks one mode.
// - Management data mode reaches PHY registers only.
// - Select fall starts, select rise ends transaction.
// - 27 header bits, five turnaround, eight data.
// - Burst address advances every eight clocks.
// - All fields travel most significant bit first.
// - Sample input on rise; output changes on fall, management data output on rise.
// - Command 011 reads, 010 writes.
// - Turnaround input bits are ignored.
// - Only low sixteen address bits decoded.
// - Two-wire slave answers one fixed address.
// - Two-wire: 16-bit address, then byte data.
// - Data line only pulled low or released.
// - Frame: preamble, start, opcode, addresses, turnaround, data.
// - PHY addresses 1h to 4h map ports 1-4.
// - PHY registers also reached through serial modes.
`timescale 1ns/10ps
module sms_mgmt_slave (
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   input  wire logic [1:0]        mode_strap_in,
   input  wire logic              spi_clk_in,
   input  wire logic              spi_select_n_in,
   input  wire logic              spi_serial_in,
   output logic                   spi_serial_out,
   input  wire logic              i2c_scl_in,
   input  wire logic              i2c_sda_in,
   output logic                   i2c_sda_out,
   output logic                   i2c_sda_oe_n_out,
   input  wire logic              mdc_in,
   input  wire logic              mdio_in,
   output logic                   mdio_out,
   output logic                   mdio_oe_n_out,
   output logic                   reg_valid_out,
   output sms_pkg::sms_req_t      reg_cmd_out,
   input  wire logic              reg_ack_in,
   input  wire logic [7:0]        reg_rdata_in,
   output logic                   phy_mgmt_mode_out
);

   typedef enum logic [2:0] {I2C_IDLE, I2C_DEV, I2C_AH, I2C_AL, I2C_WR, I2C_RD} sms_i2c_t;
   typedef enum logic [1:0] {M_PRE, M_HDR, M_TA, M_DAT} sms_mdio_t;
   typedef enum logic {ACC_IDLE, ACC_WAIT} sms_acc_t;

   // Byte address of one half of a 16-bit PHY register, high byte first.
   function automatic logic [15:0] phy_byte_addr(input logic [4:0] phy,
                                                 input logic [4:0] regn,
                                                 input logic       lo);
      phy_byte_addr = sms_pkg::PHY_REG_BASE | {phy[3:0], 12'h000} | {10'h000, regn, lo};
   endfunction

   // ****************************************************************
   // Pin synchronisers and mode strap
   // ****************************************************************
   logic [3:0]         pin_s1_r;
   logic [3:0]         pin_s2_r;
   logic [3:0]         pin_p_r;
   logic [1:0]         strap_s1_r;
   logic [1:0]         strap_s2_r;
   logic [1:0]         take_cnt_r;
   sms_pkg::sms_mode_t mode_r;
   sms_pkg::sms_mode_t strap_mode;

   // Pins are {scl, sda, mdc, mdio}; the first stage feeds only the second.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_s1_r   <= 4'hf;
         pin_s2_r   <= 4'hf;
         pin_p_r    <= 4'hf;
         strap_s1_r <= 2'h0;
         strap_s2_r <= 2'h0;
      end else begin
         pin_s1_r   <= {i2c_scl_in, i2c_sda_in, mdc_in, mdio_in};
         pin_s2_r   <= pin_s1_r;
         pin_p_r    <= pin_s2_r;
         strap_s1_r <= mode_strap_in;
         strap_s2_r <= strap_s1_r;
      end
   end

   assign strap_mode = (strap_s2_r == sms_pkg::STRAP_I2C)  ? sms_pkg::MODE_I2C  :
                       (strap_s2_r == sms_pkg::STRAP_MDIO) ? sms_pkg::MODE_MDIO :
                                                             sms_pkg::MODE_SPI;

   // The mode is taken once, a fixed number of edges after reset release.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         take_cnt_r <= 2'h0;
         mode_r     <= sms_pkg::MODE_NONE;
      end else if (take_cnt_r != 2'h3) begin
         take_cnt_r <= take_cnt_r + 2'h1;
         if (take_cnt_r == sms_pkg::STRAP_TAKE) begin
            mode_r <= strap_mode;
         end
      end
   end

   assign phy_mgmt_mode_out = (mode_r == sms_pkg::MODE_MDIO);

   // ****************************************************************
   // Four-wire serial link, clocked by the master's serial clock
   // ****************************************************************
   logic              spi_arst_n;
   logic [5:0]        spi_cnt_r;
   logic [5:0]        spi_cnt_nxt;
   logic [25:0]       spi_sh_r;
   logic              spi_rd_r;
   logic              spi_wr_r;
   logic [15:0]       spi_addr_r;
   logic [2:0]        spi_cmd;
   logic [15:0]       spi_hdr_addr;
   logic [7:0]        spi_byte;
   logic              spi_bit0;
   logic              spi_hdr_end;
   logic              spi_ev;
   logic              spi_tgl_r;
   sms_pkg::sms_req_t spi_req_r;
   logic [7:0]        spi_out_r;
   logic              spi_pulse;
   logic [7:0]        acc_rdata_r;

   // Select high holds the link logic in reset, so each frame starts clean.
   assign spi_arst_n   = rst_n_in & ~spi_select_n_in;
   assign spi_cnt_nxt  = (spi_cnt_r == sms_pkg::SPI_DATA_WRAP) ? sms_pkg::SPI_DATA_NEXT :
                         spi_cnt_r + 6'h01;
   assign spi_cmd      = spi_sh_r[25:23];
   assign spi_hdr_addr = {spi_sh_r[14:0], spi_serial_in};
   assign spi_byte     = {spi_sh_r[6:0], spi_serial_in};
   assign spi_hdr_end  = (spi_cnt_r == sms_pkg::SPI_HDR_LAST);
   assign spi_bit0     = (spi_cnt_r == sms_pkg::SPI_DATA_FIRST) ||
                         (spi_cnt_r == sms_pkg::SPI_DATA_WRAP);
   assign spi_ev       = (spi_hdr_end && spi_cmd == sms_pkg::SPI_CMD_RD) ||
                         (spi_rd_r && spi_bit0) ||
                         (spi_wr_r && spi_cnt_r == sms_pkg::SPI_DATA_LAST);

   // Input is sampled on the rising edge; turnaround bits are only shifted in and counted.
   always_ff @(posedge spi_clk_in or negedge spi_arst_n) begin
      if (!spi_arst_n) begin
         spi_cnt_r  <= 6'h00;
         spi_sh_r   <= 26'h0000000;
         spi_rd_r   <= 1'b0;
         spi_wr_r   <= 1'b0;
         spi_addr_r <= 16'h0000;
      end else begin
         spi_cnt_r <= spi_cnt_nxt;
         spi_sh_r  <= {spi_sh_r[24:0], spi_serial_in};
         if (spi_hdr_end) begin
            spi_rd_r   <= (spi_cmd == sms_pkg::SPI_CMD_RD);
            spi_wr_r   <= (spi_cmd == sms_pkg::SPI_CMD_WR);
            spi_addr_r <= spi_hdr_addr;
         end
         if (spi_cnt_r == sms_pkg::SPI_DATA_LAST) begin
            spi_addr_r <= spi_addr_r + 16'h0001;
         end
      end
   end

   // Requests go out as a toggle; fields stay still until the next one.
   // Reads fetch one byte ahead so the next burst byte is ready in time.
   always_ff @(posedge spi_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         spi_tgl_r <= 1'b0;
         spi_req_r <= '0;
      end else if (spi_ev) begin
         spi_tgl_r       <= ~spi_tgl_r;
         spi_req_r.we    <= spi_wr_r;
         spi_req_r.wdata <= spi_byte;
         spi_req_r.addr  <= spi_hdr_end ? spi_hdr_addr :
                            spi_rd_r ? spi_addr_r + 16'h0001 : spi_addr_r;
      end
   end

   // Output changes on the falling edge; bytes load at each byte start.
   always_ff @(negedge spi_clk_in or negedge spi_arst_n) begin
      if (!spi_arst_n) begin
         spi_out_r <= 8'h00;
      end else if (spi_rd_r && spi_bit0) begin
         spi_out_r <= acc_rdata_r;
      end else begin
         spi_out_r <= {spi_out_r[6:0], 1'b0};
      end
   end

   assign spi_serial_out = spi_out_r[7];

   sms_tgl_sync u_spi_sync (
      .clk_in    (clk_in),
      .rst_n_in  (rst_n_in),
      .tgl_in    (spi_tgl_r),
      .pulse_out (spi_pulse)
   );

   // ****************************************************************
   // Two-wire bus slave, oversampled on the core clock
   // ****************************************************************
   sms_i2c_t          i2c_st_r;
   logic [3:0]        i2c_bcnt_r;
   logic [7:0]        i2c_sh_r;
   logic [15:0]       i2c_addr_r;
   logic              i2c_ack_r;
   logic              i2c_oe_n_r;
   logic              i2c_go_r;
   sms_pkg::sms_req_t i2c_req_r;
   logic              scl_s;
   logic              sda_s;
   logic              scl_rise;
   logic              scl_fall;
   logic              i2c_start;
   logic              i2c_stop;
   logic [7:0]        i2c_byte;

   assign scl_s     = pin_s2_r[3];
   assign sda_s     = pin_s2_r[2];
   assign scl_rise  = scl_s & ~pin_p_r[3];
   assign scl_fall  = ~scl_s & pin_p_r[3];
   assign i2c_start = scl_s & pin_p_r[3] & pin_p_r[2] & ~sda_s;
   assign i2c_stop  = scl_s & pin_p_r[3] & ~pin_p_r[2] & sda_s;
   assign i2c_byte  = {i2c_sh_r[6:0], sda_s};

   // Bytes are taken on the eighth rise; the ninth clock carries the ack.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         i2c_st_r   <= I2C_IDLE;
         i2c_bcnt_r <= 4'h0;
         i2c_sh_r   <= 8'h00;
         i2c_addr_r <= 16'h0000;
         i2c_ack_r  <= 1'b0;
         i2c_oe_n_r <= 1'b1;
         i2c_go_r   <= 1'b0;
         i2c_req_r  <= '0;
      end else begin
         i2c_go_r <= 1'b0;
         if (mode_r != sms_pkg::MODE_I2C || i2c_stop) begin
            i2c_st_r   <= I2C_IDLE;
            i2c_ack_r  <= 1'b0;
            i2c_oe_n_r <= 1'b1;
         end else if (i2c_start) begin
            i2c_st_r   <= I2C_DEV;
            i2c_bcnt_r <= 4'h0;
            i2c_ack_r  <= 1'b0;
            i2c_oe_n_r <= 1'b1;
         end else if (i2c_st_r != I2C_IDLE && scl_rise) begin
            i2c_sh_r <= i2c_byte;
            if (i2c_bcnt_r == sms_pkg::I2C_ACK_BIT) begin
               i2c_bcnt_r <= 4'h0;
               i2c_ack_r  <= 1'b0;
               if (i2c_st_r == I2C_RD && sda_s) begin
                  i2c_st_r <= I2C_IDLE;
               end else if (i2c_st_r == I2C_RD) begin
                  i2c_addr_r <= i2c_addr_r + 16'h0001;
                  i2c_go_r   <= 1'b1;
                  i2c_req_r  <= '{we: 1'b0, addr: i2c_addr_r + 16'h0001, wdata: 8'h00};
               end
            end else begin
               i2c_bcnt_r <= i2c_bcnt_r + 4'h1;
               if (i2c_bcnt_r == sms_pkg::I2C_LAST_BIT) begin
                  case (i2c_st_r)
                     I2C_DEV: begin
                        if (i2c_byte[7:1] == sms_pkg::I2C_DEV_ADDR) begin
                           i2c_ack_r <= 1'b1;
                           i2c_st_r  <= i2c_byte[0] ? I2C_RD : I2C_AH;
                           i2c_go_r  <= i2c_byte[0];
                           i2c_req_r <= '{we: 1'b0, addr: i2c_addr_r, wdata: 8'h00};
                        end else begin
                           i2c_st_r <= I2C_IDLE;
                        end
                     end
                     I2C_AH: begin
                        i2c_addr_r[15:8] <= i2c_byte;
                        i2c_ack_r        <= 1'b1;
                        i2c_st_r         <= I2C_AL;
                     end
                     I2C_AL: begin
                        i2c_addr_r[7:0] <= i2c_byte;
                        i2c_ack_r       <= 1'b1;
                        i2c_st_r        <= I2C_WR;
                     end
                     I2C_WR: begin
                        i2c_ack_r  <= 1'b1;
                        i2c_go_r   <= 1'b1;
                        i2c_req_r  <= '{we: 1'b1, addr: i2c_addr_r, wdata: i2c_byte};
                        i2c_addr_r <= i2c_addr_r + 16'h0001;
                     end
                     default: begin
                     end
                  endcase
               end
            end
         end else if (i2c_st_r != I2C_IDLE && scl_fall) begin
            // Data and ack change only while the clock is low.
            i2c_oe_n_r <= (i2c_bcnt_r == sms_pkg::I2C_ACK_BIT) ? ~i2c_ack_r :
                          ~(i2c_st_r == I2C_RD && !acc_rdata_r[~i2c_bcnt_r[2:0]]);
         end
      end
   end

   assign i2c_sda_out      = 1'b0;
   assign i2c_sda_oe_n_out = i2c_oe_n_r;

   // ****************************************************************
   // Management data slave, oversampled on the core clock
   // ****************************************************************
   sms_mdio_t   m_st_r;
   logic [5:0]  m_ones_r;
   logic [3:0]  m_cnt_r;
   logic [15:0] m_sh_r;
   logic [15:0] m_dat_r;
   logic [4:0]  m_phy_r;
   logic [4:0]  m_reg_r;
   logic        m_rd_r;
   logic        m_ok_r;
   logic [1:0]  m_pend_r;
   logic        m_lo_r;
   logic        m_oe_n_r;
   logic        mdc_rise;
   logic        mdio_s;
   logic [12:0] m_hdr;
   logic        m_hdr_ok;
   logic        m_drive;
   logic        m_go;
   logic        acc_done;
   sms_acc_t    acc_st_r;
   sms_pkg::sms_req_t acc_cmd_r;

   assign mdc_rise = pin_s2_r[1] & ~pin_p_r[1];
   assign mdio_s   = pin_s2_r[0];
   assign m_hdr    = {m_sh_r[11:0], mdio_s};
   assign m_hdr_ok = m_hdr[12] &&
                     (m_hdr[11:10] == sms_pkg::MDIO_OP_RD || m_hdr[11:10] == sms_pkg::MDIO_OP_WR);
   // Low for the second turnaround bit, then each zero data bit.
   assign m_drive  = m_rd_r && m_ok_r &&
                     ((m_st_r == M_TA && m_cnt_r == 4'h0) ||
                      (m_st_r == M_TA && !m_dat_r[15]) ||
                      (m_st_r == M_DAT && m_cnt_r != sms_pkg::MDIO_DAT_LAST &&
                       !m_dat_r[4'he - m_cnt_r]));
   assign m_go     = (m_pend_r != 2'h0);

   // Frame walker; frame steps happen on a rising management clock, byte requests and read data on any core cycle.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         m_st_r   <= M_PRE;
         m_ones_r <= 6'h00;
         m_cnt_r  <= 4'h0;
         m_sh_r   <= 16'h0000;
         m_dat_r  <= 16'h0000;
         m_phy_r  <= 5'h00;
         m_reg_r  <= 5'h00;
         m_rd_r   <= 1'b0;
         m_ok_r   <= 1'b0;
         m_pend_r <= 2'h0;
         m_lo_r   <= 1'b0;
         m_oe_n_r <= 1'b1;
      end else begin
         if (m_go && acc_st_r == ACC_IDLE && mode_r == sms_pkg::MODE_MDIO) begin
            m_pend_r <= m_pend_r - 2'h1;
            m_lo_r   <= 1'b1;
         end
         if (acc_done && !acc_cmd_r.we && mode_r == sms_pkg::MODE_MDIO) begin
            if (acc_cmd_r.addr[0]) m_dat_r[7:0] <= reg_rdata_in;
            else m_dat_r[15:8] <= reg_rdata_in;
         end
         if (mode_r != sms_pkg::MODE_MDIO) begin
            m_st_r   <= M_PRE;
            m_oe_n_r <= 1'b1;
         end else if (mdc_rise) begin
            m_sh_r   <= {m_sh_r[14:0], mdio_s};
            m_cnt_r  <= m_cnt_r + 4'h1;
            m_oe_n_r <= ~m_drive;
            case (m_st_r)
               M_PRE: begin
                  if (mdio_s && m_ones_r != sms_pkg::MDIO_PRE_ONES) begin
                     m_ones_r <= m_ones_r + 6'h01;
                  end else if (!mdio_s) begin
                     m_ones_r <= 6'h00;
                     m_cnt_r  <= 4'h0;
                     if (m_ones_r == sms_pkg::MDIO_PRE_ONES) m_st_r <= M_HDR;
                  end
               end
               M_HDR: begin
                  if (m_cnt_r == sms_pkg::MDIO_HDR_LAST) begin
                     m_cnt_r <= 4'h0;
                     m_st_r  <= m_hdr_ok ? M_TA : M_PRE;
                     m_rd_r  <= (m_hdr[11:10] == sms_pkg::MDIO_OP_RD);
                     m_phy_r <= m_hdr[9:5];
                     m_reg_r <= m_hdr[4:0];
                     m_ok_r  <= m_hdr[9:5] >= sms_pkg::PHY_FIRST &&
                                m_hdr[9:5] <= sms_pkg::PHY_LAST;
                     if (m_hdr_ok && m_hdr[11:10] == sms_pkg::MDIO_OP_RD &&
                         m_hdr[9:5] >= sms_pkg::PHY_FIRST && m_hdr[9:5] <= sms_pkg::PHY_LAST) begin
                        m_pend_r <= 2'h2;
                        m_lo_r   <= 1'b0;
                     end
                  end
               end
               M_TA: begin
                  if (m_cnt_r == sms_pkg::MDIO_TA_LAST) begin
                     m_cnt_r <= 4'h0;
                     m_st_r  <= M_DAT;
                  end
               end
               M_DAT: begin
                  if (m_cnt_r == sms_pkg::MDIO_DAT_LAST) begin
                     m_st_r <= M_PRE;
                     if (!m_rd_r && m_ok_r) begin
                        m_dat_r  <= {m_sh_r[14:0], mdio_s};
                        m_pend_r <= 2'h2;
                        m_lo_r   <= 1'b0;
                     end
                  end
               end
               default: m_st_r <= M_PRE;
            endcase
         end
      end
   end

   assign mdio_out      = 1'b0;
   assign mdio_oe_n_out = m_oe_n_r;

   // ****************************************************************
   // Byte access engine toward the register file
   // ****************************************************************
   logic              acc_go;
   sms_pkg::sms_req_t acc_req;
   sms_pkg::sms_req_t m_req;

   // Management data reaches only the PHY register window.
   assign m_req   = '{we: ~m_rd_r,
                      addr: phy_byte_addr(m_phy_r, m_reg_r, m_lo_r),
                      wdata: m_lo_r ? m_dat_r[7:0] : m_dat_r[15:8]};
   assign acc_go  = (acc_st_r == ACC_IDLE) &&
                    ((mode_r == sms_pkg::MODE_SPI && spi_pulse) ||
                     (mode_r == sms_pkg::MODE_I2C && i2c_go_r) ||
                     (mode_r == sms_pkg::MODE_MDIO && m_go));
   assign acc_req = (mode_r == sms_pkg::MODE_SPI) ? spi_req_r :
                    (mode_r == sms_pkg::MODE_I2C) ? i2c_req_r : m_req;
   assign acc_done = (acc_st_r == ACC_WAIT) && reg_ack_in;

   // One request at a time; read data stays put until the next read.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         acc_st_r    <= ACC_IDLE;
         acc_cmd_r   <= '0;
         acc_rdata_r <= 8'h00;
      end else if (acc_go) begin
         acc_st_r  <= ACC_WAIT;
         acc_cmd_r <= acc_req;
      end else if (acc_done) begin
         acc_st_r <= ACC_IDLE;
         if (!acc_cmd_r.we) acc_rdata_r <= reg_rdata_in;
      end
   end

   assign reg_valid_out = (acc_st_r == ACC_WAIT);
   assign reg_cmd_out   = acc_cmd_r;

endmodule // sms_mgmt_slave

// ===== testbench/sms_mgmt_slave_chk.sv
// Port checks for the management serial slave.
`timescale 1ns/10ps
module sms_chk (
   input wire logic              clk_in,
   input wire logic              rst_n_in,
   input wire logic              spi_select_n_in,
   input wire logic              spi_serial_out,
   input wire logic              i2c_sda_out,
   input wire logic              mdio_out,
   input wire logic              mdio_oe_n_out,
   input wire logic              reg_valid_out,
   input wire sms_pkg::sms_req_t reg_cmd_out,
   input wire logic              reg_ack_in,
   input wire logic              phy_mgmt_mode_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // Access handshake, mode and pin drive checks.
   a_valid_hold: assert property (reg_valid_out && !reg_ack_in |=> reg_valid_out)
      else $error("Access dropped early.");
   a_cmd_stable: assert property (reg_valid_out && !reg_ack_in |=> $stable(reg_cmd_out))
      else $error("Access command moved.");
   a_valid_end: assert property (reg_valid_out && reg_ack_in |=> !reg_valid_out)
      else $error("Access did not end.");
   a_mdio_low: assert property (mdio_out == 1'b0)
      else $error("Data line driven high.");
   a_sda_low: assert property (i2c_sda_out == 1'b0)
      else $error("Bus data driven high.");
   a_mode_hold: assert property (phy_mgmt_mode_out |=> phy_mgmt_mode_out)
      else $error("Mode changed.");
   a_phy_only: assert property (reg_valid_out && phy_mgmt_mode_out |->
      reg_cmd_out.addr[15:8] inside {8'h11, 8'h21, 8'h31, 8'h41})
      else $error("Non PHY access.");
   a_mdio_idle: assert property (!phy_mgmt_mode_out |-> mdio_oe_n_out)
      else $error("Data line driven.");
   a_spi_quiet: assert property (spi_select_n_in |-> !spi_serial_out)
      else $error("Output active while deselected.");
   c_write: cover property (reg_valid_out && reg_ack_in && reg_cmd_out.we);
   c_read: cover property (reg_valid_out && reg_ack_in && !reg_cmd_out.we);
   c_frame: cover property ($fell(spi_select_n_in));
endmodule // sms_chk
bind sms_mgmt_slave sms_chk i_sms_chk (.*);

// ===== testbench/sms_reg_model.sv
// Byte register file answering the slave's access port.
`timescale 1ns/10ps
module sms_reg_model (
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   input  wire logic              valid_in,
   input  wire sms_pkg::sms_req_t cmd_in,
   output logic                   ack_out,
   output logic [7:0]             rdata_out
);
   logic [7:0] mem_r [64];
   logic [1:0] cnt_r;
   // Acks three cycles late; read data churns outside the ack cycle.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_r <= 2'h0;
         ack_out <= 1'b0;
         rdata_out <= 8'h00;
      end else begin
         ack_out <= 1'b0;
         rdata_out <= ~rdata_out;
         if (valid_in && !ack_out) begin
            cnt_r <= cnt_r + 2'h1;
            if (cnt_r == 2'h2) begin
               ack_out <= 1'b1;
               cnt_r <= 2'h0;
               rdata_out <= mem_r[cmd_in.addr[5:0]];
               if (cmd_in.we) mem_r[cmd_in.addr[5:0]] <= cmd_in.wdata;
            end
         end
      end
   end
endmodule // sms_reg_model

// ===== testbench/tb_top.sv
// Self-checking bench for the management slave in four-wire and management data modes.
`timescale 1ns/10ps
module tb_top;
   localparam int HALF = 507;
   typedef struct {logic [23:0] a; logic [7:0] d;} sms_row_t;
   logic clk_in, rst_n_in, spi_clk_in, spi_select_n_in, spi_serial_in, spi_serial_out;
   logic i2c_scl_in = 1'b1, i2c_sda_in = 1'b1, mdc_in = 1'b0, mdio_m = 1'b1;
   logic i2c_sda_out, i2c_sda_oe_n_out, mdio_out, mdio_oe_n_out, reg_valid_out;
   logic reg_ack_in, phy_mgmt_mode_out;
   logic [1:0] mode_strap_in;
   logic [7:0] reg_rdata_in;
   logic [15:0] r;
   wire mdio_in = mdio_m & mdio_oe_n_out;
   sms_pkg::sms_req_t reg_cmd_out;
   int errors, compares, cyc;
   sms_row_t rows [3] = '{'{24'h000010, 8'ha5}, '{24'hff1101, 8'h3c}, '{24'h00003f, 8'h00}};
   sms_mgmt_slave i_sms_mgmt_slave (.*);
   sms_reg_model i_sms_reg_model (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .valid_in(reg_valid_out), .cmd_in(reg_cmd_out), .ack_out(reg_ack_in),
      .rdata_out(reg_rdata_in));
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   // A hang counts as a mismatch.
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 40000) begin
         errors++;
         results();
      end
   end
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // One frame: header, five ignored turnaround ones, n data bytes.
   task automatic spi(input logic [2:0] c, input logic [23:0] a, input logic [15:0] w,
                      input int n);
      logic [47:0] f;
      f = {c, a, 5'h1f, w};
      r = 16'h0000;
      @(negedge clk_in) spi_select_n_in = 1'b0;
      for (int i = 0; i < 32 + 8 * n; i++) begin
         spi_serial_in = f[47-i];
         #HALF;
         if (i >= 32) r = {r[14:0], spi_serial_out};
         spi_clk_in = 1'b1;
         #HALF;
         spi_clk_in = 1'b0;
      end
      #HALF;
      spi_select_n_in = 1'b1;
      spi_serial_in = ~spi_serial_in;
      #(8 * HALF);
   endtask
   // One mgmt data frame, MDC at 2 MHz.
   task automatic mdio(input logic [63:0] f);
      for (int i = 0; i < 64; i++) begin
         mdio_m = f[63-i];
         repeat (10) @(negedge clk_in);
         mdc_in = 1'b1;
         if (i > 47) r = {r[14:0], mdio_in};
         repeat (10) @(negedge clk_in);
         mdc_in = 1'b0;
      end
   endtask
   task automatic results();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      {rst_n_in, spi_clk_in, spi_serial_in, mode_strap_in} = 5'h00;
      spi_select_n_in = 1'b1;
      repeat (12) @(negedge clk_in);
      chk("reset", {reg_valid_out, spi_serial_out, mdio_oe_n_out, i2c_sda_oe_n_out}, 16'h3);
      rst_n_in = 1'b1;
      repeat (6) @(negedge clk_in);
      chk("mode", phy_mgmt_mode_out, 16'h0);
      foreach (rows[k]) begin
         spi(sms_pkg::SPI_CMD_WR, rows[k].a, {rows[k].d, 8'h00}, 1);
         spi(sms_pkg::SPI_CMD_RD, {8'h5a, rows[k].a[15:0]}, 16'h0000, 1);
         chk("read", r, {8'h00, rows[k].d});
         $display("row %0d done", k);
      end
      spi(sms_pkg::SPI_CMD_WR, 24'h000020, 16'h1234, 2);
      spi(sms_pkg::SPI_CMD_RD, 24'h000020, 16'h0000, 2);
      chk("burst", r, 16'h1234);
      $display("burst done");
      spi(3'h1, 24'h000010, 16'hff00, 1);
      spi(sms_pkg::SPI_CMD_RD, 24'h000010, 16'h0000, 1);
      chk("bad cmd", r, 16'h00a5);
      $display("bad command done");
      @(negedge clk_in) {rst_n_in, mode_strap_in} = 3'h2;
      repeat (2) @(negedge clk_in);
      rst_n_in = 1'b1;
      repeat (6) @(negedge clk_in);
      chk("mode", phy_mgmt_mode_out, 16'h1);
      mdio({32'hffffffff, 4'h6, 5'h01, 23'h43ffff});
      chk("phy read", r, 16'h1234);
      mdio({32'hffffffff, 4'h6, 5'h05, 23'h43ffff});
      chk("no phy", r, 16'hffff);
      $display("mdio done");
      results();
   end
endmodule // tb_top
